// >>> hdl/controller_port_pin_mux.sv
`timescale 1ns/100ps
module controller_port_pin_mux
	import pin_mux_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [1:0] host_if_select_in,
	input wire logic hiz_and_reset_pin_in,
	input wire logic tx_mode_sel_b1_in,
	input wire logic tx_mode_sel_b2_in,
	input wire logic [7:0] bus_pin_in,
	output logic [7:0] bus_pin_out,
	output logic [7:0] bus_pin_oe_out,
	input wire logic int_pin_in,
	output logic int_pin_out,
	output logic int_pin_oe_out,
	input wire logic [EVT_W-1:0] event_in,
	input wire logic ale_in,
	input wire logic par_rd_en_in,
	input wire logic [7:0] par_rd_data_in,
	input wire logic ser_out_en_in,
	input wire logic ser_data_in,
	output logic [7:0] par_data_out,
	output logic [7:0] mux_addr_out,
	output ser_in_t ser_out,
	output hw_cfg_t hw_cfg_out,
	output host_if_t mode_out,
	output logic hiz_out,
	output logic cfg_reset_out,
	output logic irq_out
);
	// Register file state
	logic [EVT_W-1:0] status_q, status_d;
	logic [EVT_W-1:0] enable_q, enable_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic irq_q, irq_d;
	// Pin side state
	logic hiz_prev_q, hiz_prev_d;
	logic cfg_reset_q, cfg_reset_d;
	logic hiz_q, hiz_d;
	host_if_t mode_q, mode_d;
	logic [7:0] pin_out_q, pin_out_d;
	logic [7:0] pin_oe_q, pin_oe_d;
	logic int_oe_q, int_oe_d;
	logic [7:0] par_data_q, par_data_d;
	logic [7:0] mux_addr_q, mux_addr_d;
	ser_in_t ser_q, ser_d;
	hw_cfg_t hw_cfg_q, hw_cfg_d;
	host_if_t sel;
	logic rst_edge;
	logic pending;
	logic apb_setup;
	logic apb_done;

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		addr_known = (a == STATUS_OFS) || (a == ENABLE_OFS) || (a == CLEAR_OFS) ||
			(a == MODE_OFS) || (a == CTRL_OFS);
	endfunction

	assign sel = host_if_t'(host_if_select_in);
	assign rst_edge = hiz_and_reset_pin_in && !hiz_prev_q;
	assign pending = |(status_q & enable_q);
	// One wait state: answer on the second access cycle
	assign apb_setup = psel_in && penable_in && !pready_q;
	assign apb_done = psel_in && penable_in && pready_q;

	always_comb
	begin
		status_d = status_q;
		enable_d = enable_q;
		ctrl_d = ctrl_q;
		prdata_d = 32'h0000_0000;
		pready_d = apb_setup;
		pslverr_d = 1'b0;
		if (apb_setup)
		begin
			pslverr_d = !addr_known(paddr_in);
			if (!pwrite_in)
			begin
				unique case (paddr_in)
					STATUS_OFS: prdata_d[EVT_W-1:0] = status_q;
					ENABLE_OFS: prdata_d[EVT_W-1:0] = enable_q;
					MODE_OFS: prdata_d = {21'h0, hw_cfg_q, mode_q};
					CTRL_OFS: prdata_d[1:0] = ctrl_q;
					default: prdata_d = 32'h0000_0000;
				endcase
			end
		end
		if (apb_done && pwrite_in)
		begin
			if (paddr_in == ENABLE_OFS)
				enable_d = pwdata_in[EVT_W-1:0];
			if (paddr_in == CTRL_OFS)
				ctrl_d = pwdata_in[1:0];
			if (paddr_in == CLEAR_OFS)
				status_d = status_q & ~pwdata_in[EVT_W-1:0];
		end
		// A new event wins over a clear in the same cycle
		status_d = status_d | event_in;
		if (rst_edge)
		begin
			status_d = '0; // RL3
			enable_d = ENABLE_RST; // RL4
			ctrl_d = CTRL_RST; // RL4
		end
		irq_d = |(status_d & enable_d);
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			status_q <= '0;
			enable_q <= ENABLE_RST;
			ctrl_q <= CTRL_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			enable_q <= enable_d;
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	always_comb
	begin
		hiz_prev_d = hiz_and_reset_pin_in;
		cfg_reset_d = rst_edge; // RL3
		hiz_d = hiz_and_reset_pin_in;
		mode_d = sel; // RL7
		pin_out_d = 8'h00;
		pin_oe_d = 8'h00;
		int_oe_d = 1'b0;
		par_data_d = par_data_q;
		mux_addr_d = mux_addr_q;
		ser_d = ser_q;
		hw_cfg_d = hw_cfg_q;
		unique case (sel)
			IF_PAR_MUX:
			begin
				if (ale_in)
					mux_addr_d = bus_pin_in; // RL9
				else
					par_data_d = bus_pin_in; // RL9
				if (par_rd_en_in && !ale_in && ctrl_q[CTRL_PAR_EN_BIT])
				begin
					pin_out_d = par_rd_data_in;
					pin_oe_d = 8'hFF;
				end
			end
			IF_PAR_NONMUX:
			begin
				par_data_d = bus_pin_in; // RL8
				if (par_rd_en_in && ctrl_q[CTRL_PAR_EN_BIT])
				begin
					pin_out_d = par_rd_data_in; // RL8
					pin_oe_d = 8'hFF;
				end
			end
			IF_SERIAL:
			begin
				ser_d.sclk = bus_pin_in[PIN_SER_CLK]; // RL16
				ser_d.mosi = bus_pin_in[PIN_SER_MOSI];
				pin_out_d[PIN_SER_MISO] = ser_data_in; // RL17
				pin_oe_d[PIN_SER_MISO] = ser_out_en_in; // RL17
			end
			IF_HARDWARE:
			begin
				// Pins stay undriven; sampled as static straps
				hw_cfg_d.rx_term_disable = bus_pin_in[PIN_RX_TERM]; // RL10
				hw_cfg_d.tx_term_disable = bus_pin_in[PIN_TX_TERM]; // RL11
				hw_cfg_d.rx_mode_sel_b1 = bus_pin_in[PIN_RX_MODE1]; // RL12
				hw_cfg_d.rx_mode_sel_b0 = bus_pin_in[PIN_RX_MODE0]; // RL12
				hw_cfg_d.tx_mode_sel_b2 = tx_mode_sel_b2_in; // RL13
				hw_cfg_d.tx_mode_sel_b1 = tx_mode_sel_b1_in; // RL13
				hw_cfg_d.tx_sync_pin_function_sel = bus_pin_in[PIN_TX_SYNC]; // RL14
				hw_cfg_d.rx_sync_pin_function_sel = bus_pin_in[PIN_RX_SYNC]; // RL15
				hw_cfg_d.jitter_atten_clk_select = int_pin_in; // RL2
			end
		endcase
		// Event request pin is open-drain and pulls low only
		if (sel != IF_HARDWARE)
			int_oe_d = pending && ctrl_q[CTRL_INT_EN_BIT]; // RL1
		if (hiz_and_reset_pin_in)
		begin
			pin_oe_d = 8'h00; // RL5
			int_oe_d = 1'b0; // RL5
		end
		if (rst_edge)
		begin
			hw_cfg_d = HW_CFG_RST; // RL4
			par_data_d = 8'h00;
			mux_addr_d = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			hiz_prev_q <= 1'b0;
			cfg_reset_q <= 1'b0;
			hiz_q <= 1'b0;
			mode_q <= IF_PAR_MUX;
			pin_out_q <= 8'h00;
			pin_oe_q <= 8'h00;
			int_oe_q <= 1'b0;
			par_data_q <= 8'h00;
			mux_addr_q <= 8'h00;
			ser_q <= '0;
			hw_cfg_q <= HW_CFG_RST;
		end
		else
		begin
			hiz_prev_q <= hiz_prev_d;
			cfg_reset_q <= cfg_reset_d;
			hiz_q <= hiz_d;
			mode_q <= mode_d;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			int_oe_q <= int_oe_d;
			par_data_q <= par_data_d;
			mux_addr_q <= mux_addr_d;
			ser_q <= ser_d;
			hw_cfg_q <= hw_cfg_d;
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign irq_out = irq_q;
	assign bus_pin_out = pin_out_q;
	assign bus_pin_oe_out = pin_oe_q;
	assign int_pin_out = 1'b0;
	assign int_pin_oe_out = int_oe_q;
	assign par_data_out = par_data_q;
	assign mux_addr_out = mux_addr_q;
	assign ser_out = ser_q;
	assign hw_cfg_out = hw_cfg_q;
	assign mode_out = mode_q;
	assign hiz_out = hiz_q;
	assign cfg_reset_out = cfg_reset_q;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	a_irq_pin_low: assert property ( // RL1
		(pending && ctrl_q[CTRL_INT_EN_BIT] && sel != IF_HARDWARE && !hiz_and_reset_pin_in)
		|=> int_pin_oe_out && !int_pin_out)
		else $error("event request pin not pulled low");
	a_reset_pulse: assert property ( // RL3
		$rose(hiz_and_reset_pin_in) |=> cfg_reset_out ##1 !cfg_reset_out)
		else $error("pin edge gave no single reset pulse");
	a_reset_defaults: assert property ( // RL4
		cfg_reset_out |-> enable_q == ENABLE_RST && ctrl_q == CTRL_RST &&
		hw_cfg_out == HW_CFG_RST)
		else $error("registers not at defaults after pin reset");
	a_hiz_float: assert property ( // RL5
		hiz_and_reset_pin_in |=> bus_pin_oe_out == 8'h00 && !int_pin_oe_out)
		else $error("pin driven while float requested");
	a_mode_follow: assert property ( // RL7
		##1 mode_out == $past(host_if_select_in))
		else $error("mode does not follow select");
	a_nonmux_data: assert property ( // RL8
		sel == IF_PAR_NONMUX && !hiz_and_reset_pin_in && !$rose(hiz_and_reset_pin_in)
		|=> par_data_out == $past(bus_pin_in))
		else $error("nonmuxed data not captured");
	a_mux_addr: assert property ( // RL9
		sel == IF_PAR_MUX && ale_in && !$rose(hiz_and_reset_pin_in)
		|=> mux_addr_out == $past(bus_pin_in))
		else $error("muxed address not latched");
	a_hw_term: assert property ( // RL10 RL11
		sel == IF_HARDWARE && !$rose(hiz_and_reset_pin_in)
		|=> hw_cfg_out.rx_term_disable == $past(bus_pin_in[PIN_RX_TERM]) &&
		hw_cfg_out.tx_term_disable == $past(bus_pin_in[PIN_TX_TERM]))
		else $error("termination straps wrong");
	a_hw_modes: assert property ( // RL12 RL13
		sel == IF_HARDWARE && !$rose(hiz_and_reset_pin_in)
		|=> {hw_cfg_out.rx_mode_sel_b1, hw_cfg_out.rx_mode_sel_b0} ==
		$past(bus_pin_in[PIN_RX_MODE1:PIN_RX_MODE0]) &&
		hw_cfg_out.tx_mode_sel_b1 == $past(tx_mode_sel_b1_in) &&
		hw_cfg_out.tx_mode_sel_b2 == $past(tx_mode_sel_b2_in))
		else $error("mode straps wrong");
	a_hw_sync: assert property ( // RL14 RL15
		sel == IF_HARDWARE && !$rose(hiz_and_reset_pin_in)
		|=> hw_cfg_out.tx_sync_pin_function_sel == $past(bus_pin_in[PIN_TX_SYNC]) &&
		hw_cfg_out.rx_sync_pin_function_sel == $past(bus_pin_in[PIN_RX_SYNC]))
		else $error("sync function straps wrong");
	a_ser_clk: assert property ( // RL16
		sel == IF_SERIAL |=> ser_out.sclk == $past(bus_pin_in[PIN_SER_CLK]))
		else $error("serial clock not passed");
	a_miso_drive: assert property ( // RL17
		sel == IF_SERIAL && ser_out_en_in && !hiz_and_reset_pin_in
		|=> bus_pin_oe_out == 8'h01 && bus_pin_out[PIN_SER_MISO] == $past(ser_data_in))
		else $error("serial data out not driven");
	a_hw_no_drive: assert property ( // RL18
		sel == IF_HARDWARE |=> bus_pin_oe_out == 8'h00 && !int_pin_oe_out)
		else $error("shared pin driven in hardware mode");
endmodule

// >>> hdl/pin_mux_pkg.sv
// What this block does
// (RL1) Open-drain event request pin pulls low while an enabled event is pending.
// (RL2) Board drives clock select high in hardware mode for the higher clock rates.
// (RL3) A low-to-high edge on the test/reset pin resets the register set.
// (RL4) That reset returns every configuration register to its default.
// (RL5) While the test/reset pin is high, every driven pin floats.
// (RL6) Board holds the test/reset pin low for normal operation.
// (RL7) Interface select: 00 muxed, 01 nonmuxed, 10 serial, 11 hardware.
// (RL8) Select 01 uses the shared pins as an eight-bit data bus.
// (RL9) Select 00 uses the shared pins as multiplexed address and data.
// (RL10) Hardware mode: bus pin 7 disables the receive termination.
// (RL11) Hardware mode: bus pin 6 disables the transmit termination.
// (RL12) Hardware mode: bus pins 5 and 4 set the receive mode.
// (RL13) Hardware mode: two dedicated pins set the transmit mode.
// (RL14) Hardware mode: bus pin 3 sets the transmit sync pin function.
// (RL15) Hardware mode: bus pin 2 sets the receive sync pin function.
// (RL16) Serial mode: bus pin 2 is the serial clock from the host.
// (RL17) Serial mode: the device drives bus pin 0 as serial data out.
// (RL18) Hardware mode: shared pins are never driven, only sampled.
package pin_mux_pkg;
	localparam int ADDR_W = 8;
	localparam int EVT_W = 8;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CLEAR_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] MODE_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h10;
	localparam logic [EVT_W-1:0] ENABLE_RST = 8'h00;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam int CTRL_INT_EN_BIT = 0;
	localparam int CTRL_PAR_EN_BIT = 1;
	localparam int PIN_RX_TERM = 7;
	localparam int PIN_TX_TERM = 6;
	localparam int PIN_RX_MODE1 = 5;
	localparam int PIN_RX_MODE0 = 4;
	localparam int PIN_TX_SYNC = 3;
	localparam int PIN_RX_SYNC = 2;
	localparam int PIN_SER_CLK = 2;
	localparam int PIN_SER_MOSI = 1;
	localparam int PIN_SER_MISO = 0;

	typedef enum logic [1:0]
	{
		IF_PAR_MUX = 2'b00,
		IF_PAR_NONMUX = 2'b01,
		IF_SERIAL = 2'b10,
		IF_HARDWARE = 2'b11
	} host_if_t;

	typedef struct packed
	{
		logic jitter_atten_clk_select;
		logic rx_term_disable;
		logic tx_term_disable;
		logic rx_mode_sel_b1;
		logic rx_mode_sel_b0;
		logic tx_mode_sel_b2;
		logic tx_mode_sel_b1;
		logic tx_sync_pin_function_sel;
		logic rx_sync_pin_function_sel;
	} hw_cfg_t;

	localparam hw_cfg_t HW_CFG_RST = '0;

	typedef struct packed
	{
		logic sclk;
		logic mosi;
	} ser_in_t;
endpackage

// >>> sim/controller_port_pin_mux_test.sv
`timescale 1ns/100ps
module controller_port_pin_mux_test
	import pin_mux_pkg::*;
;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hiz = 0, tm1 = 0, tm2 = 0, hdrv = 1;
	logic ale = 0, rd_en = 0, ser_en = 0, ser_dat = 0, csd = 0, csv = 0;
	logic [7:0] pad = 0, hbus = 0, evt = 0, rdd = 0, bout, boe, blvl, pdat, madr;
	logic [31:0] pwd = 0, prd, r;
	logic [1:0] sel = 0;
	logic prdy, perr, ioe, iout, ilvl, hz, crst, irq, e;
	ser_in_t ser;
	hw_cfg_t hw;
	host_if_t mode;
	logic [7:0] pats [2] = '{8'hBC, 8'h43};
	int fail_count = 0, total_checks = 0, n;

	controller_port_pin_mux DUT (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .host_if_select_in(sel),
		.hiz_and_reset_pin_in(hiz), .tx_mode_sel_b1_in(tm1), .tx_mode_sel_b2_in(tm2),
		.bus_pin_in(blvl), .bus_pin_out(bout), .bus_pin_oe_out(boe), .int_pin_in(ilvl),
		.int_pin_out(iout), .int_pin_oe_out(ioe), .event_in(evt), .ale_in(ale),
		.par_rd_en_in(rd_en), .par_rd_data_in(rdd), .ser_out_en_in(ser_en),
		.ser_data_in(ser_dat), .par_data_out(pdat), .mux_addr_out(madr), .ser_out(ser),
		.hw_cfg_out(hw), .mode_out(mode), .hiz_out(hz), .cfg_reset_out(crst), .irq_out(irq));
	host_board_model board (.sys_clk_in(clk), .dev_bus_in(bout), .dev_oe_in(boe),
		.host_bus_in(hbus), .host_drive_in(hdrv), .int_oe_in(ioe), .int_drv_in(iout),
		.clk_sel_drive_in(csd), .clk_sel_in(csv), .bus_level_out(blvl), .int_level_out(ilvl));

	initial
		forever #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pad <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (prdy !== 1'b1 && k < 50);
		if (k >= 50)
			fail_count++;
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		check(r, x);
		check(e, xe);
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 8'h00;
		settle();
	endtask

	task complete_run;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#20000;
		fail_count++;
		complete_run();
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_chk(ENABLE_OFS, {24'h0, ENABLE_RST}, 1'b0);
		rd_chk(CTRL_OFS, {30'h0, CTRL_RST}, 1'b0);
		rd_chk(8'h40, 32'h0, 1'b1);
		$display("register reset test done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			sel <= 2'(i);
			settle();
			check(mode, i);
		end
		$display("mode select test done");
		@(posedge clk);
		ser_en <= 1'b1;
		rd_en <= 1'b1;
		csd <= 1'b1;
		foreach (pats[k])
		begin
			@(posedge clk);
			hbus <= pats[k];
			tm1 <= pats[k][0];
			tm2 <= pats[k][1];
			csv <= pats[k][6];
			settle();
			check(boe, 8'h00);
			check(hw.jitter_atten_clk_select, pats[k][6]);
			check(hw.rx_term_disable, pats[k][7]);
			check(hw.tx_term_disable, pats[k][6]);
			check({hw.rx_mode_sel_b1, hw.rx_mode_sel_b0}, pats[k][5:4]);
			check({hw.tx_mode_sel_b2, hw.tx_mode_sel_b1}, pats[k][1:0]);
			check(hw.tx_sync_pin_function_sel, pats[k][3]);
			check(hw.rx_sync_pin_function_sel, pats[k][2]);
		end
		rd_chk(MODE_OFS, 32'h0000_0533, 1'b0);
		$display("hardware mode test done");
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk);
			csd <= 1'b0;
			sel <= IF_SERIAL;
			ser_dat <= v[0];
			hbus <= {5'h0, v[0], ~v[0], 1'b0};
			settle();
			check(boe, 8'h01);
			check(blvl[0], v[0]);
			check(ser, {v[0], ~v[0]});
		end
		$display("serial test done");
		@(posedge clk);
		sel <= IF_PAR_NONMUX;
		ser_en <= 1'b0;
		rd_en <= 1'b0;
		hbus <= 8'hA5;
		settle();
		check(pdat, 8'hA5);
		check(boe, 8'h00);
		apb(1'b1, CTRL_OFS, 32'h3);
		hdrv <= 1'b0;
		rd_en <= 1'b1;
		rdd <= 8'h5A;
		settle();
		check(blvl, 8'h5A);
		@(posedge clk);
		sel <= IF_PAR_MUX;
		rd_en <= 1'b0;
		hdrv <= 1'b1;
		hbus <= 8'h3C;
		// Let the device release the pins before latching
		@(posedge clk);
		ale <= 1'b1;
		@(posedge clk);
		ale <= 1'b0;
		hbus <= 8'hC3;
		settle();
		check(madr, 8'h3C);
		check(pdat, 8'hC3);
		@(posedge clk);
		hdrv <= 1'b0;
		rd_en <= 1'b1;
		settle();
		check({boe, blvl}, 16'hFF5A);
		$display("parallel test done");
		apb(1'b1, ENABLE_OFS, 32'h4);
		pulse(8'h08);
		check({irq, ioe, ilvl}, 3'b001);
		pulse(8'h04);
		check({irq, ioe, ilvl}, 3'b110);
		rd_chk(STATUS_OFS, 32'h0C, 1'b0);
		apb(1'b1, CLEAR_OFS, 32'h0C);
		settle();
		check({irq, ioe, ilvl}, 3'b001);
		pulse(8'h04);
		$display("interrupt test done");
		@(posedge clk);
		hiz <= 1'b1;
		n = 0;
		repeat (4)
		begin
			@(posedge clk);
			#1;
			if (crst === 1'b1)
				n++;
		end
		check(n, 1);
		check({boe, ioe}, 9'h000);
		check(hz, 1'b1);
		@(posedge clk);
		hiz <= 1'b0;
		settle();
		check(hz, 1'b0);
		rd_chk(ENABLE_OFS, 32'h0, 1'b0);
		rd_chk(CTRL_OFS, 32'h1, 1'b0);
		rd_chk(STATUS_OFS, 32'h0, 1'b0);
		$display("pin reset test done");
		complete_run();
	end
endmodule

// >>> sim/host_board_model.sv
`timescale 1ns/100ps
module host_board_model
(
	input wire logic sys_clk_in,
	input wire logic [7:0] dev_bus_in,
	input wire logic [7:0] dev_oe_in,
	input wire logic [7:0] host_bus_in,
	input wire logic host_drive_in,
	input wire logic int_oe_in,
	input wire logic int_drv_in,
	input wire logic clk_sel_drive_in,
	input wire logic clk_sel_in,
	output logic [7:0] bus_level_out,
	output logic int_level_out
);
	logic [7:0] last_q = 8'h00;
	always_ff @(posedge sys_clk_in)
		last_q <= bus_level_out;
	// Floating bits show the inverse of their last level
	always_comb
		for (int i = 0; i < 8; i++)
			bus_level_out[i] = dev_oe_in[i] ? dev_bus_in[i] :
				host_drive_in ? host_bus_in[i] : ~last_q[i];
	// Pull-up unless pulled low or strapped
	always_comb
		int_level_out = int_oe_in ? int_drv_in : clk_sel_drive_in ? clk_sel_in : 1'b1;
endmodule
